// ### design/ring_bus_pkg.sv
// shared constants, types and crc step for the serial ring bus
package ring_bus_pkg;
	// clock and bit rate
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BIT_RATE_HZ = 500_000;
	localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE_HZ;
	localparam int BIT_CNT_W = 9;
	localparam logic [BIT_CNT_W-1:0] BIT_DIV_LAST = BIT_CNT_W'(BIT_CYC - 1);
	// stream geometry
	localparam int WORD_W = 16;
	localparam int MAX_WORDS = 256;
	localparam int MAX_SLAVES = 32;
	localparam int WORD_IDX_W = 8;
	localparam int WCNT_W = 9;
	localparam int SCNT_W = 6;
	localparam int BIT_IDX_W = 13;
	localparam logic [WCNT_W-1:0] WCNT_MAX = 9'h100;
	localparam logic [SCNT_W-1:0] SCNT_MAX = 6'h20;
	localparam logic [BIT_IDX_W-1:0] CRC_BITS = 13'h0010;
	// output word fifo
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = WORD_IDX_W + WORD_W;
	// check value
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// what each strobe on the ring carries
	typedef enum logic [1:0] {ph_data, ph_crc, ph_flush} phase_t;

	// one serial step of the 16-bit check value, msb first
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in);
		crc_step = {crc[14:0], 1'b0} ^ (((crc[15] ^ bit_in) == 1'b1) ? CRC_POLY : 16'h0000);
	endfunction : crc_step
endpackage : ring_bus_pkg

// ### design/ring_link_if.sv
// one hop of the ring: forward stream downstream, return stream upstream
`timescale 1ns/10ps
interface ring_link_if;
	import ring_bus_pkg::*;
	logic data; // forward serial bit
	logic stb; // one-cycle bit strobe
	phase_t phase; // meaning of this strobe
	logic latch; // end of frame strobe
	logic fallback; // latch applies fallback values
	logic ret; // return serial bit
	// upstream end (master or previous slave)
	modport up (output data, output stb, output phase, output latch, output fallback, input ret);
	// downstream end (slave)
	modport down (input data, input stb, input phase, input latch, input fallback, output ret);
endinterface : ring_link_if

// ### design/ring_master.sv
// ring bus master with its output word fifo
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [PW-1:0] wr_r; // write pointer
	logic [PW-1:0] rd_r; // read pointer
	logic [PW:0] cnt_r; // words held
	logic [PW:0] cnt_nxt;
	logic in_ready_r; // registered not-full
	wire push = in_valid && in_ready_r;
	wire pop = out_valid && out_ready;

	assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	assign in_ready = in_ready_r;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];

	// pointers, count and ready flag
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready_r <= 1'b0;
		end
		else
		begin
			if (push)
				wr_r <= (wr_r == PTR_LAST) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == PTR_LAST) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_nxt;
			in_ready_r <= (cnt_nxt != CNT_FULL);
		end
	end

	// data store, no reset needed
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end
endmodule : word_fifo

module ring_master
	import ring_bus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	ring_link_if.up link,
	input wire logic run,
	input wire logic [WCNT_W-1:0] word_count,
	input wire logic [SCNT_W-1:0] slave_count,
	input wire logic out_valid,
	input wire logic [WORD_IDX_W-1:0] out_addr,
	input wire logic [WORD_W-1:0] out_data,
	output logic out_ready,
	input wire logic [WORD_IDX_W-1:0] in_rd_addr,
	output logic [WORD_W-1:0] in_rd_data,
	output logic frame_done,
	output logic crc_err,
	input wire logic err_clr
);
	logic [WORD_W-1:0] out_mem [MAX_WORDS]; // words to send
	logic [WORD_W-1:0] in_mem [2*MAX_WORDS]; // two banks of returned words
	logic [BIT_CNT_W-1:0] div_r; // bit rate divider
	logic [BIT_IDX_W-1:0] bit_r; // bit index within frame
	logic [WCNT_W-1:0] wc_r; // words in this frame
	logic [SCNT_W-1:0] sc_r; // slaves in this frame
	logic bank_r; // bank software reads
	logic [15:0] crc_tx_r; // check value of sent data
	logic [15:0] crc_rx_r; // check value of returned data
	logic [WORD_W-2:0] rx_sh_r; // returned word assembly
	logic miss_r; // returned check value mismatch
	logic run_d_r; // run one cycle back
	logic fb_pend_r; // fallback owed to slaves
	logic have_r; // a good frame has been committed
	logic data_r, stb_r, latch_r, fallback_r;
	phase_t phase_r;
	logic [WORD_W-1:0] in_rd_r;
	logic done_r, err_r;
	logic fifo_valid;
	logic [FIFO_W-1:0] fifo_data;

	// config clamped to legal ranges
	wire [WCNT_W-1:0] wc_in = (word_count == '0) ? 9'h001 :
		(word_count > WCNT_MAX) ? WCNT_MAX : word_count;
	wire [SCNT_W-1:0] sc_in = (slave_count == '0) ? 6'h01 :
		(slave_count > SCNT_MAX) ? SCNT_MAX : slave_count;
	// frame layout: data bits, check bits, flush for return delay, latch
	wire tick = (div_r == BIT_DIV_LAST);
	wire [BIT_IDX_W-1:0] data_len = {wc_r, 4'h0};
	wire [BIT_IDX_W-1:0] crc_end = data_len + CRC_BITS;
	wire [BIT_IDX_W-1:0] sc_ext = {7'h00, sc_r};
	wire [BIT_IDX_W-1:0] flush_end = crc_end + sc_ext;
	wire in_data = (bit_r < data_len);
	wire in_crc = !in_data && (bit_r < crc_end);
	wire at_latch = (bit_r == flush_end);
	// farthest word goes out first so it lands deepest in the ring
	wire [WORD_IDX_W-1:0] tx_idx = WORD_IDX_W'(wc_r - 9'h001 - {4'h0, bit_r[12:4]});
	wire [WORD_W-1:0] tx_word = out_mem[tx_idx];
	wire tx_bit = tx_word[4'hF - bit_r[3:0]];
	// return stream lags by one bit per slave
	wire din = link.ret;
	wire [BIT_IDX_W-1:0] cap_idx = bit_r - sc_ext;
	wire cap_ok = (bit_r >= sc_ext);
	wire cap_data = cap_ok && (cap_idx < data_len);
	wire cap_crc = cap_ok && !(cap_idx < data_len) && (cap_idx < crc_end);
	wire cap_word = cap_data && (cap_idx[3:0] == 4'hF);
	wire [WORD_IDX_W-1:0] rx_idx = WORD_IDX_W'(wc_r - 9'h001 - {4'h0, cap_idx[12:4]});
	// the fifo drains only outside the data phase, so a frame is consistent
	wire drain = fifo_valid && !in_data;
	wire stop_edge = run_d_r && !run;

	word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(out_valid),
		.in_data({out_addr, out_data}),
		.in_ready(out_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(drain)
	);

	assign link.data = data_r;
	assign link.stb = stb_r;
	assign link.phase = phase_r;
	assign link.latch = latch_r;
	assign link.fallback = fallback_r;
	assign in_rd_data = in_rd_r;
	assign frame_done = done_r;
	assign crc_err = err_r;

	// bit rate divider, free running so the ring never stops
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || tick)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// frame sequencer and forward line
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			bit_r <= '0;
			wc_r <= 9'h001;
			sc_r <= 6'h01;
			data_r <= 1'b0;
			stb_r <= 1'b0;
			phase_r <= ph_flush;
			latch_r <= 1'b0;
			fallback_r <= 1'b0;
			crc_tx_r <= CRC_INIT;
		end
		else if (tick)
		begin
			stb_r <= 1'b1;
			latch_r <= at_latch;
			fallback_r <= at_latch && fb_pend_r;
			if (at_latch)
			begin
				bit_r <= '0;
				wc_r <= wc_in;
				sc_r <= sc_in;
				data_r <= 1'b0;
				phase_r <= ph_flush;
				crc_tx_r <= CRC_INIT;
			end
			else
			begin
				bit_r <= bit_r + 1'b1;
				if (in_data)
				begin
					data_r <= tx_bit;
					phase_r <= ph_data;
					crc_tx_r <= crc_step(crc_tx_r, tx_bit);
				end
				else if (in_crc)
				begin
					data_r <= crc_tx_r[15];
					phase_r <= ph_crc;
					crc_tx_r <= {crc_tx_r[14:0], 1'b0};
				end
				else
				begin
					data_r <= 1'b0;
					phase_r <= ph_flush;
				end
			end
		end
		else
		begin
			stb_r <= 1'b0;
			latch_r <= 1'b0;
			fallback_r <= 1'b0;
		end
	end

	// return capture, check and bank switch
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			crc_rx_r <= CRC_INIT;
			rx_sh_r <= '0;
			miss_r <= 1'b0;
			bank_r <= 1'b0;
		end
		else if (tick)
		begin
			if (at_latch)
			begin
				crc_rx_r <= CRC_INIT;
				miss_r <= 1'b0;
				if (!miss_r)
					bank_r <= !bank_r;
			end
			else if (cap_data)
			begin
				rx_sh_r <= {rx_sh_r[13:0], din};
				crc_rx_r <= crc_step(crc_rx_r, din);
			end
			else if (cap_crc)
			begin
				crc_rx_r <= {crc_rx_r[14:0], 1'b0};
				if (din != crc_rx_r[15])
					miss_r <= 1'b1;
			end
		end
	end

	// returned words go into the hidden bank
	always_ff @(posedge ref_clk)
	begin
		if (tick && cap_word)
			in_mem[{!bank_r, rx_idx}] <= {rx_sh_r, din};
	end

	// output words land from the fifo
	always_ff @(posedge ref_clk)
	begin
		if (drain)
			out_mem[fifo_data[FIFO_W-1:WORD_W]] <= fifo_data[WORD_W-1:0];
	end

	// fallback request, status flags, read port
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			run_d_r <= 1'b0;
			fb_pend_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			have_r <= 1'b0;
			in_rd_r <= WORD_RST;
		end
		else
		begin
			run_d_r <= run;
			if (stop_edge)
				fb_pend_r <= 1'b1;
			else if (tick && at_latch)
				fb_pend_r <= 1'b0;
			done_r <= tick && at_latch;
			if (tick && at_latch && miss_r)
				err_r <= 1'b1;
			else if (err_clr)
				err_r <= 1'b0;
			if (tick && at_latch && !miss_r)
				have_r <= 1'b1;
			// uncommitted banks read as the reset word, never as stale memory
			in_rd_r <= have_r ? in_mem[{bank_r, in_rd_addr}] : WORD_RST;
		end
	end
endmodule : ring_master

// ### design/ring_slave.sv
// ring bus slave: one 16-bit stage with regeneration and loopback
`timescale 1ns/10ps
module ring_slave
	import ring_bus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	ring_link_if.down up,
	output logic dn_data,
	output logic dn_stb,
	output phase_t dn_phase,
	output logic dn_latch,
	output logic dn_fallback,
	input wire logic dn_ret,
	input wire logic ring_end,
	input wire logic fallback_en,
	input wire logic [WORD_W-1:0] in_word,
	input wire logic [WORD_W-1:0] fallback_word,
	output logic [WORD_W-1:0] out_word,
	output logic crc_err
);
	logic [WORD_W-1:0] sh_r; // this stage of the ring shift register
	logic [15:0] crc_tx_r; // check value of what we sent on
	logic [15:0] crc_rx_r; // check value of what we took in
	logic miss_r; // forward check mismatch this frame
	logic data_r, stb_r, latch_r, fb_r, ret_r;
	phase_t phase_r;
	logic [WORD_W-1:0] out_r;
	logic err_r;

	// bit we put out on this strobe
	wire is_data = up.stb && !up.latch && (up.phase == ph_data);
	wire is_crc = up.stb && !up.latch && (up.phase == ph_crc);
	wire emit = is_data ? sh_r[WORD_W-1] : (is_crc ? crc_tx_r[15] : 1'b0);

	assign dn_data = data_r;
	assign dn_stb = stb_r;
	assign dn_phase = phase_r;
	assign dn_latch = latch_r;
	assign dn_fallback = fb_r;
	assign up.ret = ret_r;
	assign out_word = out_r;
	assign crc_err = err_r;

	// regenerated forward line and return line
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			data_r <= 1'b0;
			stb_r <= 1'b0;
			phase_r <= ph_flush;
			latch_r <= 1'b0;
			fb_r <= 1'b0;
			ret_r <= 1'b0;
		end
		else
		begin
			stb_r <= up.stb;
			latch_r <= up.stb && up.latch;
			fb_r <= up.stb && up.fallback;
			if (up.stb)
			begin
				data_r <= emit;
				phase_r <= up.phase;
				ret_r <= ring_end ? emit : dn_ret;
			end
		end
	end

	// shift stage, check values and frame latch
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sh_r <= WORD_RST;
			crc_tx_r <= CRC_INIT;
			crc_rx_r <= CRC_INIT;
			miss_r <= 1'b0;
			out_r <= WORD_RST;
			err_r <= 1'b0;
		end
		else if (up.stb && up.latch)
		begin
			// latch: fallback word if requested and enabled, else our word on a good frame; offer our input next frame
			if (up.fallback && fallback_en)
				out_r <= fallback_word;
			else if (!miss_r)
				out_r <= sh_r;
			sh_r <= in_word;
			err_r <= miss_r;
			miss_r <= 1'b0;
			crc_tx_r <= CRC_INIT;
			crc_rx_r <= CRC_INIT;
		end
		else if (is_data)
		begin
			sh_r <= {sh_r[WORD_W-2:0], up.data};
			crc_tx_r <= crc_step(crc_tx_r, emit);
			crc_rx_r <= crc_step(crc_rx_r, up.data);
		end
		else if (is_crc)
		begin
			crc_tx_r <= {crc_tx_r[14:0], 1'b0};
			crc_rx_r <= {crc_rx_r[14:0], 1'b0};
			if (up.data != crc_rx_r[15])
				miss_r <= 1'b1;
		end
	end
endmodule : ring_slave

// ### bench/ring_link_asserts.sv
// assertions on the master-side ring link
`timescale 1ns/10ps
module ring_link_asserts
	import ring_bus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic data,
	input wire logic stb,
	input wire phase_t phase,
	input wire logic latch,
	input wire logic fallback,
	input wire logic ret
);
	logic [8:0] gap_r; // cycles since last strobe
	logic seen_r; // first strobe already seen
	phase_t last_ph_r; // phase of previous strobe
	logic [12:0] data_cnt_r; // data strobes this frame
	logic [4:0] crc_cnt_r; // check strobes this frame
	logic [5:0] flush_cnt_r; // flush strobes this frame
	// strobe spacing and phase history
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			gap_r <= 9'h000;
			seen_r <= 1'b0;
			last_ph_r <= ph_flush;
		end
		else
		begin
			gap_r <= stb ? 9'h000 : gap_r + 9'h001;
			seen_r <= seen_r | stb;
			last_ph_r <= stb ? phase : last_ph_r;
		end
	end
	// per-frame counts, cleared by the latch strobe
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || (stb && latch))
		begin
			data_cnt_r <= 13'h0000;
			crc_cnt_r <= 5'h00;
			flush_cnt_r <= 6'h00;
		end
		else if (stb)
		begin
			data_cnt_r <= data_cnt_r + 13'((phase == ph_data) ? 1 : 0);
			crc_cnt_r <= crc_cnt_r + 5'((phase == ph_crc) ? 1 : 0);
			flush_cnt_r <= flush_cnt_r + 6'((phase == ph_flush) ? 1 : 0);
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// data and phase held, no strobe, between bits
	sequence s_quiet;
		(!stb && $stable(data) && $stable(phase))[*8];
	endsequence
	// return bit settles one cycle after the strobe
	sequence s_ret_hold;
		##1 $stable(ret)[*8];
	endsequence
	property p_bit_gap;
		stb && seen_r |-> gap_r == BIT_DIV_LAST;
	endproperty
	property p_hold;
		stb |=> s_quiet;
	endproperty
	property p_ret_hold;
		stb |=> s_ret_hold;
	endproperty
	property p_latch_stb;
		latch |-> stb;
	endproperty
	property p_fb_latch;
		fallback |-> latch && stb;
	endproperty
	property p_latch_order;
		stb && latch |-> last_ph_r == ph_flush && flush_cnt_r >= 6'h01 && flush_cnt_r <= 6'h20;
	endproperty
	property p_crc_len;
		stb && !latch && phase == ph_flush && last_ph_r == ph_crc |-> crc_cnt_r == 5'h10;
	endproperty
	property p_data_len;
		stb && phase == ph_crc && last_ph_r == ph_data
			|-> data_cnt_r[3:0] == 4'h0 && data_cnt_r != 13'h0000 && data_cnt_r <= 13'h1000;
	endproperty
	a_bit_gap: assert property (p_bit_gap) else $error("bit strobe spacing wrong");
	a_hold: assert property (p_hold) else $error("forward bit not held");
	a_ret_hold: assert property (p_ret_hold) else $error("return bit not held");
	a_latch_stb: assert property (p_latch_stb) else $error("latch without strobe");
	a_fb_latch: assert property (p_fb_latch) else $error("fallback off latch");
	a_latch_order: assert property (p_latch_order) else $error("bad flush count");
	a_crc_len: assert property (p_crc_len) else $error("check field not 16 bits");
	a_data_len: assert property (p_data_len) else $error("data not whole words");
endmodule : ring_link_asserts

// ### bench/ring_shift_io_bus_master_tb.sv
// bench: master with two slaves, and a master with a faulty far end
`timescale 1ns/10ps
module ring_shift_io_bus_master_tb;
	import ring_bus_pkg::*;
	typedef struct packed {logic [7:0] addr; logic [15:0] out_val; logic [15:0] in_val;} row_t;
	// output address, output word, slave input word
	localparam row_t ROWS [2] = '{'{8'h00, 16'hA55A, 16'h1234}, '{8'h01, 16'h0FF1, 16'hC3E7}};
	logic ref_clk, out_ready, frame_done, crc_err, crc_err_b;
	logic sys_rst = 1'b1, run = 1'b1, out_valid = 1'b0, err_clr = 1'b0, saw_fb = 1'b0;
	logic [WCNT_W-1:0] word_count = 9'h002; // two words, one per slave
	logic [SCNT_W-1:0] slave_count = 6'h02;
	logic [WORD_IDX_W-1:0] out_addr = 8'h00, in_rd_addr = 8'h00;
	logic [WORD_W-1:0] out_data = 16'h0000, in_rd_data, in_rd_data_b, fb_word = 16'h5AA5;
	logic [WORD_W-1:0] in_s [2] = '{ROWS[0].in_val, ROWS[1].in_val}; // slave inputs
	logic [WORD_W-1:0] out_word_s [2]; // slave outputs
	logic crc_err_s [2];
	logic fb_en [2] = '{1'b1, 1'b0}; // only the first slave has fallback
	logic [31:0] dbits = '0, dsave = '0; // forward data bits seen
	logic [15:0] cbits = '0, csave = '0; // forward check bits seen
	int num_errors = 0, samples_checked = 0, acc = 0;
	ring_link_if link0 ();
	ring_link_if link1 ();
	ring_link_if link_b ();
	ring_master u_ring_master (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link0), .run(run),
		.word_count(word_count), .slave_count(slave_count), .out_valid(out_valid),
		.out_addr(out_addr), .out_data(out_data), .out_ready(out_ready), .in_rd_addr(in_rd_addr),
		.in_rd_data(in_rd_data), .frame_done(frame_done), .crc_err(crc_err), .err_clr(err_clr));
	// second master whose return line is broken
	ring_master u_ring_master_b (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_b), .run(run),
		.word_count(word_count), .slave_count(slave_count), .out_valid(1'b0),
		.out_addr(out_addr), .out_data(out_data), .out_ready(), .in_rd_addr(in_rd_addr),
		.in_rd_data(in_rd_data_b), .frame_done(), .crc_err(crc_err_b), .err_clr(err_clr));
	ring_slave u_ring_slave_a (.ref_clk(ref_clk), .sys_rst(sys_rst), .up(link0),
		.dn_data(link1.data), .dn_stb(link1.stb), .dn_phase(link1.phase), .dn_latch(link1.latch),
		.dn_fallback(link1.fallback), .dn_ret(link1.ret), .ring_end(1'b0), .fallback_en(fb_en[0]),
		.in_word(in_s[0]), .fallback_word(fb_word), .out_word(out_word_s[0]),
		.crc_err(crc_err_s[0]));
	ring_slave u_ring_slave_b (.ref_clk(ref_clk), .sys_rst(sys_rst), .up(link1), .dn_data(),
		.dn_stb(), .dn_phase(), .dn_latch(), .dn_fallback(), .dn_ret(1'b0), .ring_end(1'b1),
		.fallback_en(fb_en[1]), .in_word(in_s[1]), .fallback_word(fb_word),
		.out_word(out_word_s[1]), .crc_err(crc_err_s[1]));
	ring_link_asserts u_ring_link_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.data(link0.data), .stb(link0.stb), .phase(link0.phase), .latch(link0.latch),
		.fallback(link0.fallback), .ret(link0.ret));
	// 200 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// faulty far end: return line flips every bit
	always @(posedge ref_clk)
		if (sys_rst)
			link_b.ret <= 1'b0;
		else if (link_b.stb)
			link_b.ret <= ~link_b.ret;
	// record forward bits of each frame
	always @(posedge ref_clk)
	begin
		if (link0.stb && link0.latch)
		begin
			dsave <= dbits;
			csave <= cbits;
			saw_fb <= saw_fb | link0.fallback;
		end
		else if (link0.stb && link0.phase == ph_data)
			dbits <= {dbits[30:0], link0.data};
		else if (link0.stb && link0.phase == ph_crc)
			cbits <= {cbits[14:0], link0.data};
	end
	// compare and count
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			num_errors++;
		end
	endtask : check
	// reference check value, msb first
	function automatic logic [15:0] exp_crc(input logic [31:0] d);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : exp_crc
	// wait for the end of a frame, bounded
	task automatic wait_frame();
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (frame_done !== 1'b1 && n < 30000);
		check("frame end", 16'h0001, 16'(n < 30000));
		repeat (4) @(posedge ref_clk);
	endtask : wait_frame
	// verdict and end of run
	task automatic report_and_stop();
		$display("checked %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// cut a hang short
	initial
	begin
		repeat (85000) @(posedge ref_clk);
		num_errors++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		repeat (5) @(posedge ref_clk);
		// outputs as reset leaves them
		check("reset read", WORD_RST, in_rd_data);
		check("reset flag", 16'h0000, 16'(crc_err));
		check("reset ready", 16'h0000, 16'(out_ready));
		$display("test reset done");
		sys_rst <= 1'b0;
		out_valid <= 1'b1;
		out_data <= ~ROWS[0].out_val;
		// fill the master's fifo in the first data phase until it refuses;
		// the last write to each address carries the row's word, so order matters
		repeat (12)
		begin
			@(posedge ref_clk);
			if (out_ready === 1'b1)
				acc++;
			out_addr <= WORD_IDX_W'(acc % 2);
			out_data <= (acc >= 6) ? ROWS[acc % 2].out_val : ~ROWS[acc % 2].out_val;
		end
		out_valid <= 1'b0;
		check("fifo fill", 16'(FIFO_DEPTH), 16'(acc));
		check("fifo ready", 16'h0000, 16'(out_ready));
		// no draining while data bits go out
		repeat (1000) @(posedge ref_clk);
		check("fifo hold", 16'h0000, 16'(out_ready));
		wait_frame();
		check("fifo drained", 16'h0001, 16'(out_ready));
		// one more write is taken at once
		out_valid <= 1'b1;
		out_addr <= ROWS[1].addr;
		out_data <= ROWS[1].out_val;
		@(posedge ref_clk);
		check("fifo accept", 16'h0001, 16'(out_ready));
		out_valid <= 1'b0;
		$display("test fifo done");
		wait_frame();
		// clear a flag left by the short reset frame
		err_clr <= 1'b1;
		@(posedge ref_clk);
		err_clr <= 1'b0;
		wait_frame();
		check("stream first word", ROWS[1].out_val, dsave[31:16]);
		check("stream last word", ROWS[0].out_val, dsave[15:0]);
		check("check field", exp_crc({ROWS[1].out_val, ROWS[0].out_val}), csave);
		check("return check", 16'h0000, 16'(crc_err));
		for (int i = 0; i < 2; i++)
		begin
			in_rd_addr <= ROWS[i].addr;
			repeat (2) @(posedge ref_clk);
			check("slave output", ROWS[i].out_val, out_word_s[i]);
			check("slave check", 16'h0000, 16'(crc_err_s[i]));
			check("input word", ROWS[i].in_val, in_rd_data);
			check("dropped input", WORD_RST, in_rd_data_b);
		end
		$display("test frames done");
		run <= 1'b0;
		wait_frame();
		check("fallback strobe", 16'h0001, 16'(saw_fb));
		check("fallback slave", fb_word, out_word_s[0]);
		check("no fallback slave", ROWS[1].out_val, out_word_s[1]);
		$display("test fallback done");
		check("error flag", 16'h0001, 16'(crc_err_b));
		err_clr <= 1'b1;
		@(posedge ref_clk);
		err_clr <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("error cleared", 16'h0000, 16'(crc_err_b));
		$display("test error flag done");
		report_and_stop();
	end
endmodule : ring_shift_io_bus_master_tb
